// file: core/rtf_front_end.sv
// telegram sorting, compliance mode, set value checks, supply loss
module rtf_front_end
	import rtf_pkg::*;
#(
	parameter int unsigned WAIT_CYCLES = ALARM_WAIT_CYC
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic rx_valid,
	input wire rtf_byte_t rx_in,
	input wire logic rx_net,
	input wire logic [15:0] rx_port,
	input wire logic port_cfg_wr,
	input wire logic [15:0] port_cfg_val,
	input wire logic wr_valid,
	input wire rtf_wr_t wr_cmd,
	input wire logic [15:0] lim_min,
	input wire logic [15:0] lim_max,
	input wire logic variant_103,
	input wire logic nv_mode_in,
	input wire logic supply_loss_alarm,
	input wire logic post_alarm_restore_setting,
	input wire logic alarm_clear,
	input wire logic dc_on_req,
	input wire logic dc_off_req,
	output logic bin_valid_q,
	output rtf_byte_t bin_out_q,
	output logic bin_crc_q,
	output logic txt_valid_q,
	output rtf_byte_t txt_out_q,
	output logic proto_err_q,
	output logic [7:0] resp_addr_q,
	output logic coil_std_fmt_q,
	output logic strict_q,
	output logic nv_save_q,
	output logic [15:0] text_port_q,
	output logic wr_ack_q,
	output logic wr_err_q,
	output logic [15:0] set_code_q,
	output logic [14:0] set_eff_q,
	output logic [15:0] thr_code_q,
	output logic dc_on_q,
	output logic alarm_flag_q
);

	////////////////////////////////////////////////////////////////////////
	// first core byte decides the route of the whole telegram
	function automatic rtf_route_t classify(input logic [7:0] b,
		input logic strict, input logic framed);
		rtf_route_t r;
		r = RT_IGN;
		if (b == ADDR_BCAST || (b == ADDR_UNIT && strict)) begin
			r = RT_BIN; // see (RULE1)
		end else if (b >= ERR_LO && b <= ERR_HI) begin
			r = RT_ERR; // see (RULE2)
		end else if (b >= TEXT_MIN) begin
			// the binary port never carries text
			r = framed ? RT_ERR : RT_TEXT; // see (RULE3) see (RULE8)
		end
		return r;
	endfunction : classify

	////////////////////////////////////////////////////////////////////////
	rtf_rx_state_t rx_q, rx_d;
	logic [2:0] hdr_q, hdr_d;
	logic framed_q, framed_d;
	logic bin_valid_d, txt_valid_d, proto_err_d, bin_crc_d;
	rtf_byte_t bin_out_d, txt_out_d;
	logic [7:0] resp_addr_d;
	logic [15:0] text_port_d;
	rtf_route_t route;
	logic start_framed;

	always_comb begin
		rx_d = rx_q;
		hdr_d = hdr_q;
		framed_d = framed_q;
		bin_valid_d = 1'b0;
		txt_valid_d = 1'b0;
		proto_err_d = 1'b0;
		bin_out_d = bin_out_q;
		txt_out_d = txt_out_q;
		bin_crc_d = bin_crc_q;
		resp_addr_d = resp_addr_q;
		text_port_d = text_port_q;
		route = RT_IGN;
		start_framed = rx_net && (rx_port == TCP_BIN_PORT); // see (RULE8)
		if (port_cfg_wr) begin
			text_port_d = port_cfg_val; // see (RULE9)
		end
		if (rx_valid && rx_in.sof && start_framed) begin
			// header bytes come first; unit address follows them
			framed_d = 1'b1; // see (RULE10)
			hdr_d = 3'h1;
			rx_d = rx_in.eof ? RX_IDLE : RX_HDR;
		end else if (rx_valid && (rx_in.sof ||
			(rx_q == RX_HDR && hdr_q == HDR_LEN))) begin
			if (rx_in.sof) begin
				framed_d = 1'b0;
			end
			route = classify(rx_in.data, strict_q, framed_d);
			unique case (route)
				RT_BIN: begin
					bin_valid_d = 1'b1;
					bin_out_d = rx_in;
					bin_out_d.sof = 1'b1;
					// no trailing checksum on the framed form
					bin_crc_d = !framed_d; // see (RULE10)
					// legacy accepts only 0, so it answers with 0
					resp_addr_d = strict_q ? rx_in.data : ADDR_BCAST; // see (RULE5)
					rx_d = RX_BIN;
				end
				RT_TEXT: begin
					txt_valid_d = 1'b1;
					txt_out_d = rx_in;
					rx_d = RX_TEXT; // see (RULE3)
				end
				RT_ERR: begin
					proto_err_d = 1'b1;
					rx_d = RX_DROP;
				end
				RT_IGN: begin
					rx_d = RX_DROP;
				end
			endcase
			if (rx_in.eof) begin
				rx_d = RX_IDLE;
			end
		end else if (rx_valid) begin
			unique case (rx_q)
				RX_IDLE: begin
					rx_d = RX_IDLE;
				end
				RX_HDR: begin
					hdr_d = hdr_q + 3'h1;
				end
				RX_BIN: begin
					bin_valid_d = 1'b1;
					bin_out_d = rx_in;
				end
				RX_TEXT: begin
					txt_valid_d = 1'b1;
					txt_out_d = rx_in;
				end
				RX_DROP: begin
					rx_d = RX_DROP;
				end
				default: begin
					rx_d = RX_IDLE;
				end
			endcase
			if (rx_in.eof) begin
				rx_d = RX_IDLE;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			rx_q <= RX_IDLE;
			hdr_q <= 3'h0;
			framed_q <= 1'b0;
			bin_valid_q <= 1'b0;
			txt_valid_q <= 1'b0;
			proto_err_q <= 1'b0;
			bin_out_q <= '0;
			txt_out_q <= '0;
			bin_crc_q <= 1'b1;
			resp_addr_q <= ADDR_BCAST;
			text_port_q <= TEXT_PORT_DEF; // see (RULE9)
		end else begin
			rx_q <= rx_d;
			hdr_q <= hdr_d;
			framed_q <= framed_d;
			bin_valid_q <= bin_valid_d;
			txt_valid_q <= txt_valid_d;
			proto_err_q <= proto_err_d;
			bin_out_q <= bin_out_d;
			txt_out_q <= txt_out_d;
			bin_crc_q <= bin_crc_d;
			resp_addr_q <= resp_addr_d;
			text_port_q <= text_port_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// mode and set value writes
	logic range_ok;
	logic loaded_q, loaded_d;
	logic strict_d, nv_save_d, coil_std_fmt_d, wr_ack_d, wr_err_d;
	logic [15:0] set_code_d, thr_code_d;
	logic [14:0] set_eff_d;

	rtf_range_chk u_chk (
		.code(wr_cmd.data),
		.thresh(wr_cmd.thresh),
		.variant_103(variant_103),
		.lim_min(lim_min),
		.lim_max(lim_max),
		.ok(range_ok)
	);

	always_comb begin
		loaded_d = 1'b1;
		strict_d = strict_q;
		nv_save_d = 1'b0;
		wr_ack_d = 1'b0;
		wr_err_d = 1'b0;
		set_code_d = set_code_q;
		thr_code_d = thr_code_q;
		// stored mode is taken once, just after reset release
		if (!loaded_q) begin
			strict_d = nv_mode_in; // see (RULE4)
		end else if (wr_valid && wr_cmd.reg_addr == REG_COMPLIANCE) begin
			if (wr_cmd.data <= MODE_STRICT) begin
				strict_d = (wr_cmd.data == MODE_STRICT); // see (RULE4)
				nv_save_d = 1'b1;
				wr_ack_d = 1'b1;
			end else begin
				wr_err_d = 1'b1;
			end
		end else if (wr_valid && range_ok) begin
			wr_ack_d = 1'b1;
			if (wr_cmd.thresh) begin
				thr_code_d = wr_cmd.data;
			end else begin
				set_code_d = wr_cmd.data;
			end
		end else if (wr_valid) begin
			wr_err_d = 1'b1; // see (RULE20)
		end
		coil_std_fmt_d = strict_d; // see (RULE6)
		// msb is sign, so the dac sees half the code
		set_eff_d = set_code_d[15:1]; // see (RULE14) see (RULE11)
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			loaded_q <= 1'b0;
			strict_q <= 1'b0;
			nv_save_q <= 1'b0;
			coil_std_fmt_q <= 1'b0;
			wr_ack_q <= 1'b0;
			wr_err_q <= 1'b0;
			set_code_q <= 16'h0000;
			thr_code_q <= 16'h0000;
			set_eff_q <= 15'h0000;
		end else begin
			loaded_q <= loaded_d;
			strict_q <= strict_d;
			nv_save_q <= nv_save_d;
			coil_std_fmt_q <= coil_std_fmt_d;
			wr_ack_q <= wr_ack_d;
			wr_err_q <= wr_err_d;
			set_code_q <= set_code_d;
			thr_code_q <= thr_code_d;
			set_eff_q <= set_eff_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// supply loss supervision
	logic alarm_s;
	rtf_al_state_t al_q, al_d;
	logic [31:0] wait_q, wait_d;
	logic dc_on_d, dc_was_q, dc_was_d, alarm_flag_d;

	rtf_sync3 u_sync (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.pin(supply_loss_alarm),
		.level_q(alarm_s)
	);

	always_comb begin
		al_d = al_q;
		wait_d = wait_q;
		dc_on_d = dc_on_q;
		dc_was_d = dc_was_q;
		alarm_flag_d = alarm_flag_q;
		if (alarm_s) begin
			// a new loss always restarts the wait
			if (al_q == AL_RUN) begin
				dc_was_d = dc_on_q;
			end
			al_d = AL_DOWN;
			dc_on_d = 1'b0; // see (RULE15)
			alarm_flag_d = 1'b1;
			wait_d = 32'h0000_0000;
		end else begin
			unique case (al_q)
				AL_RUN: begin
					if (dc_off_req) begin
						dc_on_d = 1'b0;
					end else if (dc_on_req) begin
						dc_on_d = 1'b1;
					end
				end
				AL_DOWN: begin
					al_d = AL_HOLD; // see (RULE15)
				end
				AL_HOLD: begin
					// early clears are ignored; no ready signal exists
					wait_d = wait_q + 32'h0000_0001; // see (RULE18)
					if (wait_q == WAIT_CYCLES - 32'h0000_0001) begin
						if (post_alarm_restore_setting) begin
							al_d = AL_RUN;
							alarm_flag_d = 1'b0;
							dc_on_d = dc_was_q; // see (RULE16)
						end else begin
							al_d = AL_WAITCLR;
						end
					end
				end
				AL_WAITCLR: begin
					if (alarm_clear) begin
						// dc stays off until the host asks again
						al_d = AL_RUN; // see (RULE17)
						alarm_flag_d = 1'b0;
					end
				end
				default: begin
					al_d = AL_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			al_q <= AL_RUN;
			wait_q <= 32'h0000_0000;
			dc_on_q <= 1'b0;
			dc_was_q <= 1'b0;
			alarm_flag_q <= 1'b0;
		end else begin
			al_q <= al_d;
			wait_q <= wait_d;
			dc_on_q <= dc_on_d;
			dc_was_q <= dc_was_d;
			alarm_flag_q <= alarm_flag_d;
		end
	end

endmodule : rtf_front_end

// file: core/rtf_pkg.sv
// constants and types shared by the remote telegram front end
//
// Functional notes
// (RULE1) accept address 0 always, 1 only strict
// (RULE2) first byte 2..41 is a protocol error
// (RULE3) first byte 42 or above goes to text parser
// (RULE4) compliance setting at 10013, legacy default, nonvolatile
// (RULE5) strict responses echo the request address
// (RULE6) strict mode always uses standard coil format
// (RULE7) host switches mode via address 0 first
// (RULE8) port 502 carries only binary framed telegrams
// (RULE9) second socket port configurable, default 5025
// (RULE10) framed telegram: header first, no checksum
// (RULE11) full scale 100 percent equals 0xCCCC
// (RULE12) ordinary set values limited to 0xD0E5
// (RULE13) thresholds up to 0xE147, or 0xD2F1 variant
// (RULE14) msb is sign, 26214 effective steps
// (RULE15) supply loss: dc off, wait after alarm clears
// (RULE16) automatic restore turns dc on after waiting; code restores the dc state held before the loss, so dc stays off if it was off
// (RULE17) manual: host clears, waits 2 s, switches on
// (RULE18) host waits about 12 s before clearing
// (RULE19) reject set values outside user limits
// (RULE20) rejected write keeps old value, flags error
package rtf_pkg;

	////////////////////////////////////////////////////////////////////////
	localparam logic [7:0] ADDR_BCAST = 8'h00;
	localparam logic [7:0] ADDR_UNIT = 8'h01;
	localparam logic [7:0] ERR_LO = 8'h02;
	localparam logic [7:0] ERR_HI = 8'h29;
	localparam logic [7:0] TEXT_MIN = 8'h2A;
	localparam logic [15:0] REG_COMPLIANCE = 16'h271D;
	localparam logic [15:0] TCP_BIN_PORT = 16'h01F6;
	localparam logic [15:0] TEXT_PORT_DEF = 16'h13A1;
	// bytes of framing header in front of the unit address
	localparam logic [2:0] HDR_LEN = 3'h6;

	////////////////////////////////////////////////////////////////////////
	localparam logic [15:0] FULL_SCALE = 16'hCCCC;
	localparam logic [15:0] SET_MAX = 16'hD0E5;
	localparam logic [15:0] THR_MAX_110 = 16'hE147;
	localparam logic [15:0] THR_MAX_103 = 16'hD2F1;
	localparam logic [15:0] EFF_STEPS = 16'h6666;
	localparam logic [15:0] MODE_STRICT = 16'h0001;

	////////////////////////////////////////////////////////////////////////
	localparam int unsigned CLK_HZ = 32'h017D_7840;
	localparam int unsigned ALARM_WAIT_MS = 32'h0000_2EE0;
	localparam int unsigned HOST_ON_WAIT_MS = 32'h0000_07D0;
	localparam int unsigned MS_PER_S = 32'h0000_03E8;
	localparam int unsigned ALARM_WAIT_CYC =
		ALARM_WAIT_MS * (CLK_HZ / MS_PER_S);

	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic sof;
		logic eof;
		logic [7:0] data;
	} rtf_byte_t;

	typedef struct packed {
		logic [15:0] reg_addr;
		logic [15:0] data;
		logic thresh;
	} rtf_wr_t;

	typedef enum logic [1:0] {
		RT_BIN = 2'h0,
		RT_TEXT = 2'h1,
		RT_ERR = 2'h2,
		RT_IGN = 2'h3
	} rtf_route_t;

	typedef enum logic [4:0] {
		RX_IDLE = 5'h01,
		RX_HDR = 5'h02,
		RX_BIN = 5'h04,
		RX_TEXT = 5'h08,
		RX_DROP = 5'h10
	} rtf_rx_state_t;

	typedef enum logic [3:0] {
		AL_RUN = 4'h1,
		AL_DOWN = 4'h2,
		AL_HOLD = 4'h4,
		AL_WAITCLR = 4'h8
	} rtf_al_state_t;

endpackage : rtf_pkg

// file: core/rtf_range_chk.sv
// range check of a percentage coded set value or threshold
module rtf_range_chk
	import rtf_pkg::*;
(
	input wire logic [15:0] code,
	input wire logic thresh,
	input wire logic variant_103,
	input wire logic [15:0] lim_min,
	input wire logic [15:0] lim_max,
	output logic ok
);

	logic [15:0] top;

	always_comb begin
		top = SET_MAX; // see (RULE12)
		if (thresh) begin
			top = variant_103 ? THR_MAX_103 : THR_MAX_110; // see (RULE13)
		end
		ok = (code <= top);
		// user limits bind ordinary set values only
		if (!thresh && (code < lim_min || code > lim_max)) begin
			ok = 1'b0; // see (RULE19)
		end
	end

endmodule : rtf_range_chk

// file: core/rtf_sync3.sv
// three stage synchroniser with agreement of the last two stages
module rtf_sync3
	import rtf_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic pin,
	output logic level_q
);

	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic level_d;

	// stage one is seen only by stage two
	always_comb begin
		level_d = level_q;
		if (s2_q == s3_q) begin
			level_d = s3_q;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			level_q <= 1'b0;
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			level_q <= level_d;
		end
	end

endmodule : rtf_sync3

// file: dv/rtf_chk_sva.sv
// port checks for the telegram front end
module rtf_chk
	import rtf_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic rx_valid,
	input wire rtf_byte_t rx_in,
	input wire logic rx_net,
	input wire logic wr_valid,
	input wire rtf_wr_t wr_cmd,
	input wire logic supply_loss_alarm,
	input wire logic bin_valid_q,
	input wire rtf_byte_t bin_out_q,
	input wire logic txt_valid_q,
	input wire logic proto_err_q,
	input wire logic [7:0] resp_addr_q,
	input wire logic coil_std_fmt_q,
	input wire logic strict_q,
	input wire logic wr_err_q,
	input wire logic [15:0] set_code_q,
	input wire logic [14:0] set_eff_q,
	input wire logic dc_on_q,
	input wire logic alarm_flag_q
);
	timeunit 1ns;
	timeprecision 1ns;
	logic hd;
	logic sw;
	assign hd = rx_valid & rx_in.sof & ~rx_net;
	assign sw = wr_valid & ~wr_cmd.thresh;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	////////////////
	property p_a0;
		hd && rx_in.data == ADDR_BCAST |=> bin_valid_q && bin_out_q.data == 0;
	endproperty
	a_a0: assert property (p_a0) else $error("address 0 lost");
	property p_a1;
		hd && rx_in.data == ADDR_UNIT && !strict_q |=> !bin_valid_q;
	endproperty
	a_a1: assert property (p_a1) else $error("address 1 taken");
	property p_err;
		hd && rx_in.data inside {[ERR_LO:ERR_HI]} |=> proto_err_q;
	endproperty
	a_err: assert property (p_err) else $error("no error");
	property p_txt;
		hd && rx_in.data >= TEXT_MIN |=> txt_valid_q && !bin_valid_q;
	endproperty
	a_txt: assert property (p_txt) else $error("text lost");
	property p_resp;
		bin_valid_q && bin_out_q.sof && strict_q |-> resp_addr_q == bin_out_q.data;
	endproperty
	a_resp: assert property (p_resp) else $error("bad echo");
	property p_coil;
		coil_std_fmt_q == strict_q;
	endproperty
	a_coil: assert property (p_coil) else $error("coil format");
	// a mode write must reach the coil format one cycle later
	property p_cfmt;
		wr_valid && wr_cmd.reg_addr == REG_COMPLIANCE && $past(reset_n)
		&& wr_cmd.data <= MODE_STRICT
		|=> coil_std_fmt_q == $past(wr_cmd.data[0]);
	endproperty
	a_cfmt: assert property (p_cfmt) else $error("coil mode");
	property p_set;
		sw && wr_cmd.reg_addr != REG_COMPLIANCE && wr_cmd.data > SET_MAX
		|=> wr_err_q && $stable(set_code_q);
	endproperty
	a_set: assert property (p_set) else $error("set kept");
	property p_thr;
		wr_valid && wr_cmd.thresh && wr_cmd.data > THR_MAX_110 |=> wr_err_q;
	endproperty
	a_thr: assert property (p_thr) else $error("ceiling");
	property p_eff;
		set_eff_q == set_code_q[15:1];
	endproperty
	a_eff: assert property (p_eff) else $error("sign bit");
	// sync takes four cycles, three stages and the agreement flop, then one more for the outputs
	property p_loss;
		$rose(supply_loss_alarm) |-> ##[3:6] (alarm_flag_q && !dc_on_q);
	endproperty
	a_loss: assert property (p_loss) else $error("dc not off");
	c_txt: cover property (txt_valid_q);
	c_one: cover property (strict_q && bin_valid_q && resp_addr_q == 1);
	c_back: cover property ($fell(alarm_flag_q) && dc_on_q);
endmodule : rtf_chk

bind rtf_front_end rtf_chk u_sva (.core_clk, .reset_n, .rx_valid, .rx_in,
	.rx_net, .wr_valid, .wr_cmd, .supply_loss_alarm, .bin_valid_q,
	.bin_out_q, .txt_valid_q, .proto_err_q, .resp_addr_q, .coil_std_fmt_q,
	.strict_q, .wr_err_q, .set_code_q, .set_eff_q, .dc_on_q, .alarm_flag_q);

// file: dv/rtf_front_end_tb_top.sv
// self checking bench for the telegram front end
module rtf_front_end_tb_top
	import rtf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned WAITC = 20;
	logic core_clk, reset_n, rx_valid, rx_net, port_cfg_wr, wr_valid;
	logic variant_103, nv_mode_in, supply_loss_alarm, alarm_clear;
	logic post_alarm_restore_setting, dc_on_req, dc_off_req;
	logic bin_valid_q, bin_crc_q, txt_valid_q, proto_err_q, coil_std_fmt_q;
	logic strict_q, nv_save_q, wr_ack_q, wr_err_q, dc_on_q, alarm_flag_q;
	logic [7:0] resp_addr_q;
	logic [15:0] rx_port, port_cfg_val, lim_min, lim_max;
	logic [15:0] text_port_q, set_code_q, thr_code_q;
	logic [14:0] set_eff_q;
	rtf_byte_t rx_in, bin_out_q, txt_out_q;
	rtf_wr_t wr_cmd;
	int err_total, comparisons, nbin, ntxt, nerr, nsave;
	rtf_host host (.core_clk, .rx_valid, .rx_in, .rx_net, .rx_port);
	rtf_front_end #(.WAIT_CYCLES(WAITC)) dut (.core_clk, .reset_n,
		.rx_valid, .rx_in, .rx_net, .rx_port, .port_cfg_wr, .port_cfg_val,
		.wr_valid, .wr_cmd, .lim_min, .lim_max, .variant_103, .nv_mode_in,
		.supply_loss_alarm, .post_alarm_restore_setting, .alarm_clear,
		.dc_on_req, .dc_off_req, .bin_valid_q, .bin_out_q, .bin_crc_q,
		.txt_valid_q, .txt_out_q, .proto_err_q, .resp_addr_q,
		.coil_std_fmt_q, .strict_q, .nv_save_q, .text_port_q, .wr_ack_q,
		.wr_err_q, .set_code_q, .set_eff_q, .thr_code_q, .dc_on_q,
		.alarm_flag_q);
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		nbin += bin_valid_q;
		ntxt += txt_valid_q;
		nerr += proto_err_q;
		nsave += nv_save_q;
	end
	////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic finish_test;
		$display("comparisons=%0d err_total=%0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : finish_test
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : cyc
	task automatic rst(input logic nv);
		reset_n = 1'b0;
		nv_mode_in = nv;
		cyc(2);
		reset_n = 1'b1;
		cyc(2);
	endtask : rst
	task automatic pulse(ref logic s);
		cyc(1);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
	endtask : pulse
	task automatic tel(input logic [7:0] b[$], input logic net,
		input logic [15:0] port, input int eb, input int et, input int ee);
		nbin = 0;
		ntxt = 0;
		nerr = 0;
		host.send(b, net, port);
		cyc(1);
		chk(nbin, eb);
		chk(ntxt, et);
		chk(nerr, ee);
	endtask : tel
	task automatic wr(input logic [15:0] a, input logic [15:0] d,
		input logic t, input logic e);
		cyc(1);
		wr_cmd = '{a, d, t};
		wr_valid = 1'b1;
		cyc(1);
		wr_valid = 1'b0;
		chk({wr_ack_q, wr_err_q}, {~e, e});
	endtask : wr
	////////////////
	task automatic t_route;
		chk(text_port_q, TEXT_PORT_DEF);
		tel('{ADDR_BCAST, 8'h03, 8'h11}, 1'b0, 0, 3, 0, 0);
		chk(bin_crc_q, 1'b1);
		chk(bin_out_q, 10'h111);
		tel('{ERR_LO, 8'h03}, 1'b0, 0, 0, 0, 1);
		tel('{ERR_HI, 8'h03}, 1'b0, 0, 0, 0, 1);
		tel('{TEXT_MIN, 8'h0A}, 1'b0, 0, 0, 2, 0);
		chk(txt_out_q, 10'h10A);
		tel('{ADDR_UNIT, 8'h03}, 1'b0, 0, 0, 0, 0);
	endtask : t_route
	task automatic t_net;
		tel('{1, 2, 3, 4, 5, 6, 0, 3, 9}, 1'b1, TCP_BIN_PORT,
			3, 0, 0);
		chk(bin_crc_q, 1'b0);
		chk(bin_out_q, 10'h109);
		tel('{1, 2, 3, 4, 5, 6, TEXT_MIN}, 1'b1, TCP_BIN_PORT,
			0, 0, 1);
		port_cfg_val = 16'h1234;
		pulse(port_cfg_wr);
		chk(text_port_q, 16'h1234);
		tel('{TEXT_MIN, 8'h0A}, 1'b1, 16'h1234, 0, 2, 0);
	endtask : t_net
	task automatic t_mode;
		wr(REG_COMPLIANCE, 16'h0002, 1'b0, 1'b1);
		nsave = 0;
		// legacy takes only address 0, but the switch here is a direct write to REG_COMPLIANCE, not a telegram
		wr(REG_COMPLIANCE, MODE_STRICT, 1'b0, 1'b0);
		chk({strict_q, coil_std_fmt_q, nv_save_q}, 3'h7);
		tel('{ADDR_UNIT, 8'h03, 8'h04}, 1'b0, 0, 3, 0, 0);
		chk(resp_addr_q, ADDR_UNIT);
		chk(nsave, 1);
		tel('{ADDR_BCAST, 8'h03}, 1'b0, 0, 2, 0, 0);
		chk(resp_addr_q, ADDR_BCAST);
		rst(1'b1);
		chk(strict_q, 1'b1);
		wr(REG_COMPLIANCE, 16'h0000, 1'b0, 1'b0);
		chk({strict_q, coil_std_fmt_q, nv_save_q}, 3'h1);
	endtask : t_mode
	task automatic t_set;
		wr(16'h0500, FULL_SCALE, 1'b0, 1'b0);
		chk(set_code_q, FULL_SCALE);
		chk(set_eff_q, EFF_STEPS);
		wr(16'h0500, SET_MAX, 1'b0, 1'b0);
		wr(16'h0500, SET_MAX + 1, 1'b0, 1'b1);
		lim_min = 16'h1000;
		wr(16'h0500, 16'h0FFF, 1'b0, 1'b1);
		lim_max = 16'h2000;
		wr(16'h0500, 16'h2001, 1'b0, 1'b1);
		chk(set_code_q, SET_MAX);
		wr(16'h0600, THR_MAX_110, 1'b1, 1'b0);
		wr(16'h0600, THR_MAX_110 + 1, 1'b1, 1'b1);
		variant_103 = 1'b1;
		wr(16'h0600, THR_MAX_103 + 1, 1'b1, 1'b1);
		chk(thr_code_q, THR_MAX_110);
		wr(16'h0600, THR_MAX_103, 1'b1, 1'b0);
		chk(thr_code_q, THR_MAX_103);
	endtask : t_set
	task automatic t_alarm;
		pulse(dc_on_req);
		supply_loss_alarm = 1'b1;
		cyc(8);
		chk({dc_on_q, alarm_flag_q}, 2'h1);
		supply_loss_alarm = 1'b0;
		cyc(10);
		chk(dc_on_q, 1'b0);
		cyc(WAITC + 4);
		chk({dc_on_q, alarm_flag_q}, 2'h2);
		post_alarm_restore_setting = 1'b0;
		supply_loss_alarm = 1'b1;
		cyc(8);
		supply_loss_alarm = 1'b0;
		cyc(8);
		pulse(alarm_clear);
		chk(alarm_flag_q, 1'b1);
		cyc(WAITC + 4);
		pulse(alarm_clear);
		chk({dc_on_q, alarm_flag_q}, 2'h0);
		// host settles after the clear before asking for dc again
		cyc(WAITC);
		pulse(dc_on_req);
		chk(dc_on_q, 1'b1);
		pulse(dc_off_req);
		chk(dc_on_q, 1'b0);
	endtask : t_alarm
	////////////////
	initial begin
		{port_cfg_wr, wr_valid, variant_103, supply_loss_alarm} = '0;
		{alarm_clear, dc_on_req, dc_off_req} = '0;
		post_alarm_restore_setting = 1'b1;
		{port_cfg_val, lim_min} = '0;
		lim_max = 16'hFFFF;
		wr_cmd = '0;
		rst(1'b0);
		t_route();
		t_net();
		t_mode();
		t_set();
		t_alarm();
		finish_test();
	end
	initial begin
		#100000;
		err_total++;
		finish_test();
	end
endmodule : rtf_front_end_tb_top

// file: dv/rtf_host.sv
// host model: sends telegrams one byte per cycle
module rtf_host
	import rtf_pkg::*;
(
	input wire logic core_clk,
	output logic rx_valid,
	output rtf_byte_t rx_in,
	output logic rx_net,
	output logic [15:0] rx_port
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		rx_valid = 1'b0;
		rx_in = '0;
		rx_net = 1'b0;
		rx_port = 16'h0000;
	end
	// sof on the first byte, framed header included
	task automatic send(input logic [7:0] b[$], input logic net,
		input logic [15:0] port);
		@(posedge core_clk);
		#1;
		rx_net = net;
		rx_port = port;
		rx_valid = 1'b1;
		foreach (b[i]) begin
			rx_in = '{i == 0, i == b.size() - 1, b[i]};
			@(posedge core_clk);
			#1;
		end
		// released line shows inverted data, never a stale copy
		rx_valid = 1'b0;
		rx_in.data = ~rx_in.data;
	endtask : send
endmodule : rtf_host
